/* File: logic/bcx_exec.sv */
// decode and execute of insert, bit clear, breakpoint and call
`timescale 1ns/100ps
`include "bcx_regs.svh"
// Overview of operation
// (RULE1) Bit-field insert copies the low msb-lsb+1 source bits into destination bits msb..lsb.
// (RULE2) Immediate bit clear with destination or source register 13 or 15 is unpredictable.
// (RULE3) Immediate bit clear writes source AND NOT expanded constant, keeping expansion carry.
// (RULE4) With flag update, N takes result bit 31, Z the zero test, C the carry, V is kept.
// (RULE5) The 16-bit register bit clear uses one field as destination and first operand, no shift.
// (RULE6) The 16-bit register bit clear updates flags only outside a conditional block.
// (RULE7) The 32-bit register bit clear takes S, type and imm3:imm2 shift; 13 or 15 unpredictable.
// (RULE8) Register bit clear shifts the second operand and writes first AND NOT shifted value.
// (RULE9) The breakpoint raises a monitor trap or a debug halt depending on debug configuration.
// (RULE10) The breakpoint executes regardless of condition and conditional block position.
// (RULE11) The breakpoint low-byte immediate is ignored by the hardware.
// (RULE12) Call offset is sign extended S:I1:I2:imm10:imm11:0 with I = not(J xor S).
// (RULE13) A call inside a conditional block other than last position is unpredictable.
// (RULE14) Call offsets are even and span -16777216 to 16777214.
// (RULE15) A passing call writes next address with bit 0 set to the link register and branches.
// (RULE16) Except breakpoint, writes happen only when the condition passes.
// (RULE17) Immediate bit clear expands i:imm3:imm8 through the shared expander with carry in.
module bcx_exec
    import bcx_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // instruction in
    input  wire logic                 instr_valid,
    input  wire logic [31:0]          instr,
    input  wire logic                 cond_pass,
    input  wire logic                 in_cond_block,
    input  wire logic                 last_in_cond_block,
    input  wire logic [31:0]          program_counter,
    input  wire logic [31:0]          next_instr_addr,
    // register and flag reads
    input  wire logic [31:0]          rn_value,
    input  wire logic [31:0]          rm_value,
    input  wire logic [31:0]          rd_value,
    input  wire bcx_pkg::bcx_flags_t  program_status_flags,
    // shared helpers
    input  wire logic [31:0]          expanded_constant,
    input  wire logic                 expand_carry,
    input  wire logic [31:0]          shifted_value,
    input  wire logic                 shift_carry,
    // debug configuration
    input  wire logic                 monitor_mode,
    // helper requests
    output logic      [11:0]          expand_field,
    output logic      [1:0]           shift_type,
    output logic      [4:0]           shift_amt,
    output logic      [3:0]           rn_sel,
    output logic      [3:0]           rm_sel,
    output logic      [3:0]           rd_sel,
    // results
    output bcx_pkg::bcx_result_t      result
);
    import bcx_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        bcx_result_t res;
    } bcx_state_t;

    bcx_state_t  st_q;
    bcx_state_t  st_d;
    bcx_op_t     op;
    bcx_fields_t f;
    logic [31:0] field_mask;
    logic [31:0] bfi_src;
    logic [31:0] bic_opnd;
    logic [31:0] bic_res;
    logic        bic_zero;
    logic        bic_carry;
    logic        i1;
    logic        i2;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb begin
        op = BCX_OP_NONE;
        f  = '0;
        i1 = ~(instr[13] ^ instr[26]); // see (RULE12)
        i2 = ~(instr[11] ^ instr[26]); // see (RULE12)
        if (instr[31:16] == `BCX_HALF_ZERO
            && instr[`BCX_BIC16_HI:`BCX_BIC16_LO] == `BCX_BIC16_OPC) begin
            op         = BCX_OP_BICR;
            f.rd       = {1'b0, instr[2:0]}; // see (RULE5)
            f.rn       = {1'b0, instr[2:0]}; // see (RULE5)
            f.rm       = {1'b0, instr[5:3]};
            f.setflags = ~in_cond_block; // see (RULE6)
            f.shift_amt = `BCX_LSL_ZERO; // see (RULE5)
        end else if (instr[31:16] == `BCX_HALF_ZERO
                     && instr[`BCX_DEBUG_BREAK_INSTR_HI:`BCX_DEBUG_BREAK_INSTR_LO] == `BCX_DEBUG_BREAK_INSTR_OPC) begin
            op = BCX_OP_DEBUG_BREAK_INSTR; // imm8 unused, see (RULE11)
        end else if (instr[31:20] == `BCX_BFI_OPC && instr[15] == 1'b0
                     && instr[19:16] != `BCX_REG_PC) begin
            op     = BCX_OP_BFI;
            f.is32 = 1'b1;
            f.rd   = instr[11:8];
            f.rn   = instr[19:16];
            f.lsb  = {instr[14:12], instr[7:6]};
            f.msb  = instr[4:0];
            f.bad_regs = (f.rd == `BCX_REG_SP) || (f.rd == `BCX_REG_PC)
                         || (f.rn == `BCX_REG_SP) || (f.msb < f.lsb); // see (RULE1)
        end else if (instr[31:27] == `BCX_T32_PFX && instr[25:21] == `BCX_BICI_OP
                     && instr[15] == 1'b0) begin
            op         = BCX_OP_BICI;
            f.is32     = 1'b1;
            f.rd       = instr[11:8];
            f.rn       = instr[19:16];
            f.setflags = instr[20];
            f.mod_imm  = {instr[26], instr[14:12], instr[7:0]}; // see (RULE17)
            f.bad_regs = (f.rd == `BCX_REG_SP) || (f.rd == `BCX_REG_PC)
                         || (f.rn == `BCX_REG_SP) || (f.rn == `BCX_REG_PC); // see (RULE2)
        end else if (instr[31:21] == `BCX_BICR_OPC) begin
            op           = BCX_OP_BICR;
            f.is32       = 1'b1;
            f.rd         = instr[11:8];
            f.rn         = instr[19:16];
            f.rm         = instr[3:0];
            f.setflags   = instr[20]; // see (RULE7)
            f.shift_type = instr[5:4]; // see (RULE7)
            f.shift_amt  = {instr[14:12], instr[7:6]}; // see (RULE7)
            f.bad_regs   = (f.rd == `BCX_REG_SP) || (f.rd == `BCX_REG_PC)
                           || (f.rn == `BCX_REG_SP) || (f.rn == `BCX_REG_PC)
                           || (f.rm == `BCX_REG_SP) || (f.rm == `BCX_REG_PC); // see (RULE7)
        end else if (instr[31:27] == `BCX_BL_OPC1 && instr[15:14] == `BCX_BL_OPC2
                     && instr[12] == 1'b1) begin
            op       = BCX_OP_BL;
            f.is32   = 1'b1;
            f.offset = {{8{instr[26]}}, i1, i2, instr[25:16], instr[10:0], 1'b0}; // see (RULE12)
            f.bad_regs = in_cond_block && !last_in_cond_block; // see (RULE13)
        end
    end

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    bcx_field_mask #(
        .WIDTH (32)
    ) u_mask (
        .lsb  (f.lsb),
        .msb  (f.msb),
        .mask (field_mask)
    );

    assign bfi_src  = rn_value << f.lsb; // see (RULE1)
    assign bic_opnd = (op == BCX_OP_BICI) ? expanded_constant : shifted_value; // see (RULE3)
    assign bic_carry = (op == BCX_OP_BICI) ? expand_carry : shift_carry; // see (RULE8)

    bcx_not_and #(
        .WIDTH (32)
    ) u_bic (
        .a    (rn_value),
        .b    (bic_opnd),
        .y    (bic_res),
        .zero (bic_zero)
    );

    // ----------------------------------------
    // execute
    // ----------------------------------------
    always_comb begin
        st_d     = st_q;
        st_d.res = '0;
        if (instr_valid && op != BCX_OP_NONE) begin
            st_d.res.done          = 1'b1;
            st_d.res.unpredictable = f.bad_regs;
            st_d.res.flags         = program_status_flags;
            case (op)
                BCX_OP_BFI: begin
                    st_d.res.reg_we   = cond_pass && !f.bad_regs; // see (RULE16)
                    st_d.res.reg_addr = f.rd;
                    st_d.res.reg_data = (rd_value & ~field_mask)
                                        | (bfi_src & field_mask); // see (RULE1)
                end
                BCX_OP_BICI, BCX_OP_BICR: begin
                    st_d.res.reg_we   = cond_pass; // see (RULE16)
                    st_d.res.reg_addr = f.rd;
                    st_d.res.reg_data = bic_res; // see (RULE3) see (RULE8)
                    st_d.res.flags_we = cond_pass && f.setflags; // see (RULE4)
                    if (f.setflags) begin
                        st_d.res.flags.n = bic_res[`BCX_SIGN_BIT]; // see (RULE4)
                        st_d.res.flags.z = bic_zero; // see (RULE4)
                        st_d.res.flags.c = bic_carry; // see (RULE4)
                    end
                end
                BCX_OP_DEBUG_BREAK_INSTR: begin
                    st_d.res.dbg_monitor = monitor_mode; // see (RULE9) see (RULE10)
                    st_d.res.dbg_halt    = ~monitor_mode; // see (RULE9) see (RULE10)
                end
                BCX_OP_BL: begin
                    st_d.res.reg_we        = cond_pass; // see (RULE15) see (RULE16)
                    st_d.res.reg_addr      = `BCX_REG_LR;
                    st_d.res.reg_data      = {next_instr_addr[31:1], 1'b1}; // see (RULE15)
                    st_d.res.branch        = cond_pass;
                    st_d.res.branch_target = program_counter + f.offset; // see (RULE14)
                end
                default: begin
                    st_d.res.done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign result       = st_q.res;
    assign expand_field = f.mod_imm;
    assign shift_type   = f.shift_type;
    assign shift_amt    = f.shift_amt;
    assign rn_sel       = f.rn;
    assign rm_sel       = f.rm;
    assign rd_sel       = f.rd;
endmodule // bcx_exec

/* File: pkg/bcx_regs.svh */
// constants for the bit-clear / insert / break / call execute block
`ifndef BCX_REGS_SVH
`define BCX_REGS_SVH
`define BCX_REG_SP        4'hD
`define BCX_REG_PC        4'hF
`define BCX_SIGN_BIT      31
`define BCX_BIC16_OPC     10'h10E
`define BCX_BIC16_HI      15
`define BCX_BIC16_LO      6
`define BCX_DEBUG_BREAK_INSTR_OPC      8'hBE
`define BCX_DEBUG_BREAK_INSTR_HI       15
`define BCX_DEBUG_BREAK_INSTR_LO       8
`define BCX_BFI_OPC       12'hF36
`define BCX_BICI_OPC      11'h782
`define BCX_BICR_OPC      11'h751
`define BCX_BL_OPC1       5'h1E
`define BCX_BL_OPC2       2'h3
`define BCX_LSL_ZERO      5'h00
`define BCX_T32_PFX       5'h1E
`define BCX_BICI_OP       5'h01
`define BCX_REG_LR        4'hE
`define BCX_HALF_ZERO     16'h0000
`endif

/* File: pkg/bcx_pkg.sv */
// types for the bit-clear / insert / break / call execute block
package bcx_pkg;
    typedef enum logic [2:0] {
        BCX_OP_NONE = 3'h0,
        BCX_OP_BFI  = 3'h1,
        BCX_OP_BICI = 3'h3,
        BCX_OP_BICR = 3'h2,
        BCX_OP_DEBUG_BREAK_INSTR = 3'h6,
        BCX_OP_BL   = 3'h7
    } bcx_op_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } bcx_flags_t;

    typedef struct packed {
        logic        reg_we;
        logic [3:0]  reg_addr;
        logic [31:0] reg_data;
        logic        flags_we;
        bcx_flags_t  flags;
        logic        branch;
        logic [31:0] branch_target;
        logic        dbg_monitor;
        logic        dbg_halt;
        logic        unpredictable;
        logic        done;
    } bcx_result_t;

    typedef struct packed {
        logic [3:0]  rd;
        logic [3:0]  rn;
        logic [3:0]  rm;
        logic        setflags;
        logic        is32;
        logic [4:0]  lsb;
        logic [4:0]  msb;
        logic [1:0]  shift_type;
        logic [4:0]  shift_amt;
        logic [11:0] mod_imm;
        logic [31:0] offset;
        logic        bad_regs;
    } bcx_fields_t;
endpackage

/* File: logic/bcx_field_mask.sv */
// mask of bits lsb..msb for the bit-field insert
`timescale 1ns/100ps
module bcx_field_mask #(
    parameter int WIDTH = 32
) (
    // field bounds
    input  wire logic [4:0]       lsb,
    input  wire logic [4:0]       msb,
    // mask out
    output logic      [WIDTH-1:0] mask
);
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            mask[i] = (i[4:0] >= lsb) && (i[4:0] <= msb);
        end
    end
endmodule // bcx_field_mask

/* File: logic/bcx_not_and.sv */
// bitwise a and not b with zero detect
`timescale 1ns/100ps
module bcx_not_and #(
    parameter int WIDTH = 32
) (
    // operands
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    // result
    output logic      [WIDTH-1:0] y,
    output logic                  zero
);
    assign y    = a & ~b;
    assign zero = (y == '0);
endmodule // bcx_not_and

/* File: test/bcx_exec_monitor.sv */
// checker for the insert / bit clear / break / call block
`timescale 1ns/100ps
module bcx_exec_monitor
    import bcx_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 instr_valid,
    input wire logic [31:0]          instr,
    input wire logic                 cond_pass,
    input wire logic                 in_cond_block,
    input wire logic [31:0]          next_instr_addr,
    input wire bcx_pkg::bcx_flags_t  program_status_flags,
    input wire logic                 monitor_mode,
    input wire logic [1:0]           shift_type,
    input wire logic [4:0]           shift_amt,
    input wire logic [3:0]           rn_sel,
    input wire logic [3:0]           rd_sel,
    input wire bcx_pkg::bcx_result_t result
);
    logic is_brk;
    logic is_b16;
    logic is_call;
    assign is_brk  = instr_valid && instr[31:16] == 16'h0 && instr[15:8] == 8'hBE;
    assign is_b16  = instr_valid && instr[31:16] == 16'h0 && instr[15:6] == 10'h10E;
    assign is_call = instr_valid && instr[31:27] == 5'h1E && instr[15:14] == 2'h3 && instr[12];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    brk_trap_a: assert property (is_brk |=> result.done && !result.reg_we
        && result.dbg_monitor == $past(monitor_mode) && result.dbg_halt != $past(monitor_mode))
        else $error("breakpoint trap wrong");
    trap_cause_a: assert property ((result.dbg_monitor || result.dbg_halt) |-> $past(is_brk))
        else $error("trap without breakpoint");
    call_link_a: assert property (is_call && cond_pass |=> result.reg_we && result.branch
        && result.reg_addr == 4'hE && result.reg_data == {$past(next_instr_addr[31:1]), 1'b1})
        else $error("call link wrong");
    call_skip_a: assert property (is_call && !cond_pass |=> !result.reg_we && !result.branch)
        else $error("failed call had effect");
    b16_flag_a: assert property (is_b16 && cond_pass |=> result.flags_we != $past(in_cond_block))
        else $error("short bit clear flag update wrong");
    b16_dec_a: assert property (is_b16 |-> shift_amt == 5'h00 && shift_type == 2'h0
        && rn_sel == {1'b0, instr[2:0]} && rd_sel == rn_sel) else $error("short bit clear decode");
    flag_nzv_a: assert property (result.flags_we |-> result.flags.n == result.reg_data[31]
        && result.flags.z == (result.reg_data == 32'h0)
        && result.flags.v == $past(program_status_flags.v)) else $error("flag values wrong");
    idle_quiet_a: assert property (!instr_valid |=> !result.done && !result.reg_we)
        else $error("result without instruction");
    cover property (is_brk ##1 result.dbg_halt);
    cover property (is_call && cond_pass ##1 result.branch);
    cover property (is_b16 && in_cond_block && cond_pass);
endmodule // bcx_exec_monitor

bind bcx_exec bcx_exec_monitor u_mon (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .cond_pass(cond_pass), .in_cond_block(in_cond_block), .next_instr_addr(next_instr_addr),
    .program_status_flags(program_status_flags), .monitor_mode(monitor_mode),
    .shift_type(shift_type), .shift_amt(shift_amt), .rn_sel(rn_sel), .rd_sel(rd_sel),
    .result(result)
);

/* File: test/tb_bcx_exec.sv */
// self-checking bench for the insert / bit clear / break / call block
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_bcx_exec;
    import bcx_pkg::*;
    localparam logic [31:0] R1 = 32'h8000_F0F1, R2 = 32'h0000_00F0, R3 = 32'h1234_5678;
    localparam logic [31:0] PC = 32'h0010_0000, NXT = 32'h0010_0004;
    typedef struct packed {
        logic [31:0] ins; logic cnd, blk, we; logic [3:0] addr; logic [31:0] dat;
        logic fwe; logic [2:0] nzc; logic unp;
    } bcx_row_t;
    bcx_row_t rows [10] = '{
        '{32'h0000_4391, 1, 0, 1, 4'h1, R1 & ~R2, 1, 3'h4, 0},
        '{32'h0000_4391, 1, 1, 1, 4'h1, R1 & ~R2, 0, 3'h0, 0},
        '{32'h0000_4391, 0, 0, 0, 4'h1, 32'h0, 0, 3'h0, 0},
        '{32'hF033_04FF, 1, 0, 1, 4'h4, R3 & ~32'hFF, 1, 3'h1, 0},
        '{32'hF032_05F0, 1, 0, 1, 4'h5, 32'h0, 1, 3'h3, 0},
        '{32'hF033_0DFF, 1, 0, 1, 4'hD, R3 & ~32'hFF, 1, 3'h1, 1},
        '{32'hEA31_1603, 1, 0, 1, 4'h6, R1 & ~(R3 >> 4), 1, 3'h4, 0},
        '{32'hEA31_160F, 1, 0, 1, 4'h6, R1, 1, 3'h4, 1},
        '{32'hF363_210F, 1, 0, 1, 4'h1, {R1[31:16], R3[7:0], R1[7:0]}, 0, 3'h0, 0},
        '{32'hF363_2107, 1, 0, 0, 4'h1, 32'h0, 0, 3'h0, 1}};
    logic core_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, cond_pass = 1'b0;
    logic in_cond_block = 1'b0, last_in_cond_block = 1'b0, monitor_mode = 1'b0;
    logic [31:0] instr = 32'h0, program_counter = PC, next_instr_addr = NXT;
    bcx_flags_t program_status_flags = 4'h5;
    logic [31:0] rf [16];
    logic [11:0] expand_field;
    logic [1:0]  shift_type;
    logic [4:0]  shift_amt;
    logic [3:0]  rn_sel, rm_sel, rd_sel;
    bcx_result_t result;
    int err_count = 0, compares = 0;
    always #5 core_clk = ~core_clk;
    bcx_exec u_bcx_exec (
        .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .cond_pass(cond_pass), .in_cond_block(in_cond_block),
        .last_in_cond_block(last_in_cond_block), .program_counter(program_counter),
        .next_instr_addr(next_instr_addr), .rn_value(rf[rn_sel]), .rm_value(rf[rm_sel]),
        .rd_value(rf[rd_sel]), .program_status_flags(program_status_flags),
        .expanded_constant({20'h0, expand_field}), .expand_carry(~program_status_flags.c),
        .shifted_value(rf[rm_sel] >> shift_amt), .shift_carry(shift_type[1]),
        .monitor_mode(monitor_mode), .expand_field(expand_field), .shift_type(shift_type),
        .shift_amt(shift_amt), .rn_sel(rn_sel), .rm_sel(rm_sel), .rd_sel(rd_sel),
        .result(result));
    task step(input logic [31:0] i, input logic c, b, l);
        @(negedge core_clk);
        instr_valid = 1'b1; instr = i; cond_pass = c; in_cond_block = b; last_in_cond_block = l;
        @(posedge core_clk);
        #1;
    endtask
    task chk_call(input logic [31:0] t);
        `CHK("target", t, result.branch_target)
        `CHK("link", {NXT[31:1], 1'b1}, result.reg_data)
        `CHK("link_addr", 4'hE, result.reg_addr)
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        final_report;
    end
    initial begin
        foreach (rf[k]) rf[k] = 32'h0;
        rf[1] = R1; rf[2] = R2; rf[3] = R3;
        repeat (4) @(negedge core_clk);
        `CHK("reset", '0, result)
        rst = 1'b0;
        $display("test reset done");
        foreach (rows[k]) begin
            step(rows[k].ins, rows[k].cnd, rows[k].blk, 1'b0);
            `CHK("done", 1'b1, result.done)
            `CHK("we", rows[k].we, result.reg_we)
            `CHK("unp", rows[k].unp, result.unpredictable)
            if (rows[k].we) `CHK("addr", rows[k].addr, result.reg_addr)
            if (rows[k].we) `CHK("data", rows[k].dat, result.reg_data)
            `CHK("fwe", rows[k].fwe, result.flags_we)
            if (rows[k].fwe) `CHK("flags", {rows[k].nzc, 1'b1}, result.flags)
        end
        $display("test table done");
        for (int m = 0; m < 2; m++) begin
            @(negedge core_clk);
            monitor_mode = m[0];
            step(32'h0000_BEA5, 1'b0, 1'b1, 1'b0);
            `CHK("mon", m[0], result.dbg_monitor)
            `CHK("halt", ~m[0], result.dbg_halt)
        end
        $display("test breakpoint done");
        step({5'h1E, 1'b1, 10'h000, 2'h3, 1'b0, 1'b1, 1'b0, 11'h000}, 1'b1, 1'b0, 1'b0);
        chk_call(PC - 32'd16777216);
        step({5'h1E, 1'b0, 10'h3FF, 2'h3, 1'b0, 1'b1, 1'b0, 11'h7FF}, 1'b1, 1'b1, 1'b1);
        chk_call(PC + 32'd16777214);
        `CHK("last_unp", 1'b0, result.unpredictable)
        step(instr, 1'b1, 1'b1, 1'b0);
        `CHK("mid_unp", 1'b1, result.unpredictable)
        step(instr, 1'b0, 1'b0, 1'b0);
        `CHK("no_branch", 1'b0, result.branch)
        step(32'h0, 1'b1, 1'b0, 1'b0);
        `CHK("unknown", 1'b0, result.done)
        $display("test call done");
        step(32'h0000_BE00, 1'b1, 1'b0, 1'b0);
        @(negedge core_clk);
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        `CHK("mid_reset", '0, result)
        @(negedge core_clk);
        rst = 1'b0;
        instr_valid = 1'b0;
        $display("test mid reset done");
        final_report;
    end
endmodule // tb_bcx_exec
